// >>> include/bcdrtc_pkg.sv
// Package with register map, field positions and constants of the RTC.
// How it works
// - Time base advances on 32 kHz edges.
// - Seconds, minutes, hours kept in BCD.
// - Day, month, year, weekday in BCD.
// - Periodic tick each second/minute/hour/day.
// - Alarm fires when time equals alarm.
// - Each interrupt has its own enable.
// - Sleep mask hides ticks, cleared at wake.
// - Year divisible by four is leap.
// - Day wraps at month length.
// - Month 01..12, weekday 0..6.
// - Hours 00..23 or 1..12 with PM.
// - Minutes and seconds wrap after 59.
// - Time writes accepted while running.
// - Run bit freezes counting, status reports it.
// - Round bit snaps to nearest minute.
// - Round bit self-clears after rounding.
// - Compensation added hourly at first second.
// - Compensated second lasts 32768 minus value.
// - New compensation value used immediately.
// - Five retained 8-bit backup bytes.
// - Power-on reset holds the whole core.
// - Both interrupts disabled after reset.
package bcdrtc_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_SEC = 6'h00;
  localparam logic [5:0] IDX_MIN = 6'h01;
  localparam logic [5:0] IDX_HOUR = 6'h02;
  localparam logic [5:0] IDX_DAY = 6'h03;
  localparam logic [5:0] IDX_MON = 6'h04;
  localparam logic [5:0] IDX_YEAR = 6'h05;
  localparam logic [5:0] IDX_WEEK = 6'h06;
  localparam logic [5:0] IDX_AL_SEC = 6'h08;
  localparam logic [5:0] IDX_AL_MIN = 6'h09;
  localparam logic [5:0] IDX_AL_HOUR = 6'h0A;
  localparam logic [5:0] IDX_AL_DAY = 6'h0B;
  localparam logic [5:0] IDX_AL_MON = 6'h0C;
  localparam logic [5:0] IDX_AL_YEAR = 6'h0D;
  localparam logic [5:0] IDX_CTRL = 6'h10;
  localparam logic [5:0] IDX_STATUS = 6'h11;
  localparam logic [5:0] IDX_IRQCFG = 6'h12;
  localparam logic [5:0] IDX_COMP_LO = 6'h13;
  localparam logic [5:0] IDX_COMP_HI = 6'h14;
  localparam logic [5:0] IDX_BKP0 = 6'h17;
  localparam int BKP_COUNT = 5;
  // Control register fields.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_ROUND = 1;
  localparam int CTRL_AUTO_COMP = 2;
  localparam int CTRL_PM_MODE = 5;
  // Status register fields.
  localparam int STAT_RUNNING = 1;
  // Interrupt configuration fields.
  localparam int IRQ_PERIOD_LSB = 0;
  localparam int IRQ_TICK_EN = 2;
  localparam int IRQ_ALARM_EN = 3;
  localparam int IRQ_SLEEP_MASK = 4;
  // Hour register PM flag in twelve-hour mode.
  localparam int HOUR_PM = 7;
  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_MON = 8'h01;
  // Oscillator ticks per second and the last count of a second.
  localparam int OSC_HZ = 32768;
  localparam logic signed [16:0] SUB_TOP = 17'(OSC_HZ - 1);
  // Periodic tick period selections.
  localparam logic [1:0] PER_SEC = 2'h0;
  localparam logic [1:0] PER_MIN = 2'h1;
  localparam logic [1:0] PER_HOUR = 2'h2;
  localparam logic [1:0] PER_DAY = 2'h3;
endpackage : bcdrtc_pkg

// >>> core/bcdrtc_top.sv
// BCD calendar real-time clock with alarm, tick and drift compensation.
`timescale 1ns/10ps
module bcdrtc_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk32kIn,
  input wire logic sleepState,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic periodic_tick_irq,
  output logic alarm_match_irq
);

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] year;
    logic [7:0] week;
    logic [7:0] alSec;
    logic [7:0] alMin;
    logic [7:0] alHour;
    logic [7:0] alDay;
    logic [7:0] alMon;
    logic [7:0] alYear;
    logic [7:0] ctrl;
    logic [7:0] irqCfg;
    logic [15:0] comp;
    logic [4:0][7:0] bkp;
    logic signed [16:0] subCnt;
    logic running;
    logic clkPrev;
    logic sleepPrev;
    logic [31:0] rdata;
    logic ready;
    logic slvErr;
    logic tickIrq;
    logic alarmIrq;
  } bcdrtc_state_s;

  bcdrtc_state_s s;
  bcdrtc_state_s next_s;

  // Advances a two-digit BCD value, wrapping from top back to bottom.
  function automatic logic [7:0] bcdInc(
    input logic [7:0] v,
    input logic [7:0] top,
    input logic [7:0] bottom
  );
    if (v == top)
    begin
      return bottom;
    end
    else if (v[3:0] == 4'h9)
    begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcdInc

  // A BCD year is a multiple of four when an even tens digit meets
  // 0, 4 or 8, or an odd tens digit meets 2 or 6.
  function automatic logic isLeap(input logic [7:0] y);
    if (y[4] == 1'b0)
    begin
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
  endfunction : isLeap

  // Last day of a month, in BCD.
  function automatic logic [7:0] lastDay(
    input logic [7:0] m,
    input logic [7:0] y
  );
    case (m)
      8'h02: return isLeap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : lastDay

  // True for the indices of the five retained backup bytes.
  function automatic logic isBkp(input logic [5:0] x);
    return (x >= bcdrtc_pkg::IDX_BKP0) &&
      (x < bcdrtc_pkg::IDX_BKP0 + 6'(bcdrtc_pkg::BKP_COUNT));
  endfunction : isBkp

  // Slot of a backup byte; only meaningful where isBkp holds.
  function automatic logic [2:0] bkpSlot(input logic [5:0] x);
    logic [5:0] off;
    off = x - bcdrtc_pkg::IDX_BKP0;
    return off[2:0];
  endfunction : bkpSlot

  // Timekeeping, interrupt generation and the APB slave share one state
  // copy so that a bus write in the same cycle as a tick simply wins.
  always_comb
  begin
    logic edge32;
    logic secTick;
    logic cMin;
    logic cHour;
    logic cDay;
    logic cMon;
    logic perEvent;
    logic [7:0] h12;
    logic [7:0] hNext;
    logic [7:0] rd;
    logic hit;
    logic [5:0] idx;
    edge32 = 1'b0;
    secTick = 1'b0;
    cMin = 1'b0;
    cHour = 1'b0;
    cDay = 1'b0;
    cMon = 1'b0;
    perEvent = 1'b0;
    h12 = 8'h00;
    hNext = 8'h00;
    rd = 8'h00;
    hit = 1'b0;
    idx = paddr[7:2];
    next_s = s;
    next_s.tickIrq = 1'b0;
    next_s.alarmIrq = 1'b0;
    next_s.clkPrev = clk32kIn;
    next_s.sleepPrev = sleepState;
    next_s.running = s.ctrl[bcdrtc_pkg::CTRL_RUN];

    // Sub-second counter steps on each rising edge of the 32 kHz clock.
    // The pin is taken as synchronous, so no synchroniser is spent here;
    // an asynchronous source would need one in front of this block.
    edge32 = clk32kIn & ~s.clkPrev;
    if (s.ctrl[bcdrtc_pkg::CTRL_RUN] && edge32)
    begin
      if (s.subCnt >= bcdrtc_pkg::SUB_TOP)
      begin
        secTick = 1'b1;
        next_s.subCnt = 17'sh00000;
      end
      else
      begin
        next_s.subCnt = s.subCnt + 17'sh00001;
      end
    end

    // Seconds, with optional round to the nearest minute.
    if (secTick)
    begin
      if (s.ctrl[bcdrtc_pkg::CTRL_ROUND])
      begin
        cMin = (s.sec >= 8'h30);
        next_s.sec = 8'h00;
        next_s.ctrl[bcdrtc_pkg::CTRL_ROUND] = 1'b0;
      end
      else
      begin
        cMin = (s.sec == 8'h59);
        next_s.sec = bcdInc(s.sec, 8'h59, 8'h00);
      end
    end

    // Minutes carry into hours.
    if (cMin)
    begin
      cHour = (s.min == 8'h59);
      next_s.min = bcdInc(s.min, 8'h59, 8'h00);
    end

    // Hours in 24-hour or 12-hour form; 11 PM to 12 AM closes the day.
    // In 12-hour form bit 7 is the PM flag and bits 4:0 the BCD hour.
    if (cHour)
    begin
      if (s.ctrl[bcdrtc_pkg::CTRL_PM_MODE])
      begin
        h12 = {3'h0, s.hour[4:0]};
        next_s.hour = s.hour;
        if (h12 == 8'h12)
        begin
          next_s.hour[4:0] = 5'h01;
        end
        else if (h12 == 8'h11)
        begin
          next_s.hour[4:0] = 5'h12;
          next_s.hour[bcdrtc_pkg::HOUR_PM] = ~s.hour[bcdrtc_pkg::HOUR_PM];
          cDay = s.hour[bcdrtc_pkg::HOUR_PM];
        end
        else
        begin
          hNext = bcdInc(h12, 8'h12, 8'h01);
          next_s.hour[4:0] = hNext[4:0];
        end
      end
      else
      begin
        cDay = (s.hour == 8'h23);
        next_s.hour = bcdInc(s.hour, 8'h23, 8'h00);
      end
    end

    // Day and weekday, then month and year.
    if (cDay)
    begin
      next_s.week = (s.week == 8'h06) ? 8'h00 : s.week + 8'h01;
      cMon = (s.day == lastDay(s.mon, s.year));
      next_s.day = bcdInc(s.day, lastDay(s.mon, s.year), 8'h01);
    end
    if (cMon)
    begin
      next_s.mon = bcdInc(s.mon, 8'h12, 8'h01);
      if (s.mon == 8'h12)
      begin
        next_s.year = bcdInc(s.year, 8'h99, 8'h00);
      end
    end

    // Drift correction: the second that starts at hh:00:01 begins from
    // the signed value, so it lasts 32768 minus that many ticks. The
    // value is read live, so a write just before takes effect.
    // A negative value starts the count below zero and so lengthens it.
    if (secTick && s.ctrl[bcdrtc_pkg::CTRL_AUTO_COMP] &&
        next_s.sec == 8'h01 && next_s.min == 8'h00)
    begin
      next_s.subCnt = {s.comp[15], s.comp};
    end

    // Periodic tick, gated by its enable and by the sleep mask.
    case (s.irqCfg[bcdrtc_pkg::IRQ_PERIOD_LSB +: 2])
      bcdrtc_pkg::PER_SEC: perEvent = secTick;
      bcdrtc_pkg::PER_MIN: perEvent = cMin;
      bcdrtc_pkg::PER_HOUR: perEvent = cHour;
      bcdrtc_pkg::PER_DAY: perEvent = cDay;
      default: perEvent = 1'b0;
    endcase
    if (perEvent && s.irqCfg[bcdrtc_pkg::IRQ_TICK_EN] &&
        !(s.irqCfg[bcdrtc_pkg::IRQ_SLEEP_MASK] && sleepState))
    begin
      next_s.tickIrq = 1'b1;
    end

    // Alarm compares the freshly advanced time and date on each second.
    // The weekday takes no part, so an alarm names one calendar date.
    if (secTick && s.irqCfg[bcdrtc_pkg::IRQ_ALARM_EN] &&
        next_s.sec == s.alSec && next_s.min == s.alMin &&
        next_s.hour == s.alHour && next_s.day == s.alDay &&
        next_s.mon == s.alMon && next_s.year == s.alYear)
    begin
      next_s.alarmIrq = 1'b1;
    end

    // Leaving sleep drops the mask; a bus write below still wins.
    if (s.sleepPrev && !sleepState)
    begin
      next_s.irqCfg[bcdrtc_pkg::IRQ_SLEEP_MASK] = 1'b0;
    end

    // Read mux; unmapped or misaligned addresses answer with an error.
    hit = (paddr[1:0] == 2'h0);
    case (idx)
      bcdrtc_pkg::IDX_SEC: rd = s.sec;
      bcdrtc_pkg::IDX_MIN: rd = s.min;
      bcdrtc_pkg::IDX_HOUR: rd = s.hour;
      bcdrtc_pkg::IDX_DAY: rd = s.day;
      bcdrtc_pkg::IDX_MON: rd = s.mon;
      bcdrtc_pkg::IDX_YEAR: rd = s.year;
      bcdrtc_pkg::IDX_WEEK: rd = s.week;
      bcdrtc_pkg::IDX_AL_SEC: rd = s.alSec;
      bcdrtc_pkg::IDX_AL_MIN: rd = s.alMin;
      bcdrtc_pkg::IDX_AL_HOUR: rd = s.alHour;
      bcdrtc_pkg::IDX_AL_DAY: rd = s.alDay;
      bcdrtc_pkg::IDX_AL_MON: rd = s.alMon;
      bcdrtc_pkg::IDX_AL_YEAR: rd = s.alYear;
      bcdrtc_pkg::IDX_CTRL: rd = s.ctrl;
      bcdrtc_pkg::IDX_STATUS:
      begin
        rd = 8'h00;
        rd[bcdrtc_pkg::STAT_RUNNING] = s.running;
      end
      bcdrtc_pkg::IDX_IRQCFG: rd = s.irqCfg;
      bcdrtc_pkg::IDX_COMP_LO: rd = s.comp[7:0];
      bcdrtc_pkg::IDX_COMP_HI: rd = s.comp[15:8];
      default:
      begin
        if (isBkp(idx))
        begin
          rd = s.bkp[bkpSlot(idx)];
        end
        else
        begin
          hit = 1'b0;
        end
      end
    endcase

    // Setup phase latches the answer; the access phase then completes
    // with pready high, which gives every transfer exactly two cycles.
    next_s.ready = 1'b0;
    if (psel && !penable)
    begin
      next_s.ready = 1'b1;
      next_s.slvErr = ~hit;
      next_s.rdata = hit ? {24'h000000, rd} : 32'h00000000;
    end

    // Writes land on the completing edge and override the counters.
    // Status and unmapped indices take no write; the backup decode keeps
    // any index past the fifth slot from naming a byte that is not there.
    if (psel && penable && s.ready && pwrite && !s.slvErr)
    begin
      case (idx)
        bcdrtc_pkg::IDX_SEC: next_s.sec = {1'b0, pwdata[6:0]};
        bcdrtc_pkg::IDX_MIN: next_s.min = {1'b0, pwdata[6:0]};
        bcdrtc_pkg::IDX_HOUR: next_s.hour = pwdata[7:0];
        bcdrtc_pkg::IDX_DAY: next_s.day = pwdata[7:0];
        bcdrtc_pkg::IDX_MON: next_s.mon = pwdata[7:0];
        bcdrtc_pkg::IDX_YEAR: next_s.year = pwdata[7:0];
        bcdrtc_pkg::IDX_WEEK: next_s.week = pwdata[7:0];
        bcdrtc_pkg::IDX_AL_SEC: next_s.alSec = pwdata[7:0];
        bcdrtc_pkg::IDX_AL_MIN: next_s.alMin = pwdata[7:0];
        bcdrtc_pkg::IDX_AL_HOUR: next_s.alHour = pwdata[7:0];
        bcdrtc_pkg::IDX_AL_DAY: next_s.alDay = pwdata[7:0];
        bcdrtc_pkg::IDX_AL_MON: next_s.alMon = pwdata[7:0];
        bcdrtc_pkg::IDX_AL_YEAR: next_s.alYear = pwdata[7:0];
        bcdrtc_pkg::IDX_CTRL: next_s.ctrl = pwdata[7:0];
        bcdrtc_pkg::IDX_IRQCFG: next_s.irqCfg = pwdata[7:0];
        bcdrtc_pkg::IDX_COMP_LO: next_s.comp[7:0] = pwdata[7:0];
        bcdrtc_pkg::IDX_COMP_HI: next_s.comp[15:8] = pwdata[7:0];
        default:
        begin
          if (isBkp(idx))
          begin
            next_s.bkp[bkpSlot(idx)] = pwdata[7:0];
          end
        end
      endcase
    end
  end

  // The only reset is power-on; it resets the whole core at once, clearing all but day and month (and their alarm copies), which load 01.
  // Backup bytes clear here too; they last only while this reset is off.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.day <= bcdrtc_pkg::RST_DAY;
      s.mon <= bcdrtc_pkg::RST_MON;
      s.alDay <= bcdrtc_pkg::RST_DAY;
      s.alMon <= bcdrtc_pkg::RST_MON;
      s.irqCfg <= bcdrtc_pkg::RST_ZERO;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state flip-flops.
  // No output is decoded, so none can glitch between clock edges.
  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slvErr;
  assign periodic_tick_irq = s.tickIrq;
  assign alarm_match_irq = s.alarmIrq;

endmodule : bcdrtc_top

// >>> testbench/bcdrtc_osc.sv
// Free-running oscillator model for the RTC time base, running at half the system clock rather than 32 kHz.
`timescale 1ns/10ps
module bcdrtc_osc (
  input wire logic clk_sys,
  output logic clk32kIn
);
  // Toggles every system cycle, the fastest rate the core can sample.
  // A real crystal is slower, which only stretches each second in time.
  initial clk32kIn = 1'b0;
  always @(posedge clk_sys)
  begin
    clk32kIn <= ~clk32kIn;
  end
endmodule : bcdrtc_osc

// >>> testbench/bcdrtc_sva.sv
// Bus and interrupt checks on the RTC top-level ports.
`timescale 1ns/10ps
module bcdrtc_sva (
  input logic clk_sys,
  input logic rstn,
  input logic clk32kIn,
  input logic sleepState,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic periodic_tick_irq,
  input logic alarm_match_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // A setup is answered in the next cycle and the answer stands once.
  a_ready_next: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_err_misalign: assert property (
    psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr)
    else $error("misaligned access not refused");
  a_err_data: assert property (
    pready && pslverr |-> prdata == 32'h00000000)
    else $error("refused access returned data");
  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h000000)
    else $error("read data above the low byte");
  a_sec_bcd: assert property (
    pready && !pwrite && paddr[7:2] == bcdrtc_pkg::IDX_SEC |-> !prdata[7])
    else $error("seconds top bit set");
  a_tick_pulse: assert property (
    periodic_tick_irq |=> !periodic_tick_irq)
    else $error("tick interrupt longer than one cycle");
  a_alarm_pulse: assert property (
    alarm_match_irq |=> !alarm_match_irq)
    else $error("alarm interrupt longer than one cycle");
  a_quiet_start: assert property (
    $rose(rstn) |-> (!periodic_tick_irq && !alarm_match_irq) [*8])
    else $error("interrupt right after reset");
  // Main scenarios seen at the pins.
  c_refused: cover property (pready && pslverr);
  c_tick: cover property (periodic_tick_irq);
  c_alarm: cover property (alarm_match_irq && periodic_tick_irq);
endmodule : bcdrtc_sva

// >>> testbench/bcdrtc_top_tb_top.sv
// Self-checking bench for the RTC: registers and one calendar tick.
`timescale 1ns/10ps
module bcdrtc_top_tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic clk32kIn;
  logic sleepState = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic periodic_tick_irq;
  logic alarm_match_irq;
  int failures = 0;
  int n_checks = 0;
  int nTick = 0;
  int nAlarm = 0;
  logic [31:0] seed = 32'h00000029;
  logic [32:0] expQ[$];
  localparam logic [7:0] RST [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
    8'h00, 8'h00};
  localparam logic [7:0] AFT [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h03,
    8'h01, 8'h01};

  always #25 clk_sys = ~clk_sys;

  bcdrtc_top dut (.clk_sys, .rstn, .clk32kIn, .sleepState, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .periodic_tick_irq, .alarm_match_irq);
  bcdrtc_osc u_osc (.clk_sys, .clk32kIn);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // One APB transfer; its expected error flag and data are queued first.
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, input logic [32:0] e);
    int i;
    expQ.push_back(e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1)
    begin
      failures++;
      close_out();
    end
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [5:0] x, input logic [7:0] d);
    xfer(1'b1, {x, 2'h0}, d, 33'h000000000);
  endtask : wr

  task automatic rd(input logic [5:0] x, input logic [7:0] d);
    xfer(1'b0, {x, 2'h0}, 8'h00, {25'h0000000, d});
  endtask : rd

  // At the completing edge the outputs still show the values that stood
  // before it, which is where the slave's answer is taken.
  always @(posedge clk_sys)
  begin
    if (psel && penable && pready === 1'b1 && expQ.size() > 0)
    begin
      chk("pslverr", {31'h0, pslverr}, {31'h0, expQ[0][32]});
      if (!pwrite)
        chk("prdata", prdata, expQ[0][31:0]);
      void'(expQ.pop_front());
    end
    if (periodic_tick_irq === 1'b1)
      nTick++;
    if (alarm_match_irq === 1'b1)
      nAlarm++;
  end

  // Main sequence: reset values, register access, then one tick.
  initial
  begin
    logic [7:0] v;
    logic [5:0] a;
    int k;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    for (k = 0; k < 7; k++)
      rd(6'(k), RST[k]);
    rd(6'h0B, 8'h01);
    rd(6'h12, 8'h00);
    rd(6'h10, 8'h00);
    $display("test reset values done");
    for (k = 0; k < 7; k++)
    begin
      seed = xs(seed);
      v = seed[7:0];
      a = (k < 5) ? 6'h17 + 6'(k) : 6'h0E + 6'(k);
      wr(a, v);
      rd(a, v);
    end
    wr(6'h00, 8'hFF);
    rd(6'h00, 8'h7F);
    wr(6'h11, 8'hFF);
    rd(6'h11, 8'h00);
    xfer(1'b0, 8'h70, 8'h00, {1'b1, 32'h00000000});
    xfer(1'b1, 8'h01, 8'h55, {1'b1, 32'h00000000});
    rd(6'h00, 8'h7F);
    $display("test access done");
    wr(6'h12, 8'h10);
    rd(6'h12, 8'h10);
    @(posedge clk_sys);
    sleepState <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sleepState <= 1'b0;
    rd(6'h12, 8'h00);
    $display("test sleep mask done");
    // Mode bit 5 stays 0: it is never touched while counting.
    wr(6'h10, 8'h01);
    rd(6'h11, 8'h02);
    wr(6'h12, 8'h0F);
    wr(6'h0C, 8'h03);
    wr(6'h0D, 8'h01);
    wr(6'h00, 8'h45);
    wr(6'h01, 8'h59);
    wr(6'h02, 8'h23);
    wr(6'h03, 8'h28);
    wr(6'h04, 8'h02);
    wr(6'h05, 8'h01);
    wr(6'h10, 8'h03);
    for (k = 0; k < 70000 && alarm_match_irq !== 1'b1; k++)
      @(negedge clk_sys);
    if (k == 70000)
    begin
      failures++;
      close_out();
    end
    repeat (2) @(posedge clk_sys);
    for (k = 0; k < 7; k++)
      rd(6'(k), AFT[k]);
    rd(6'h10, 8'h01);
    chk("tick count", nTick, 1);
    chk("alarm count", nAlarm, 1);
    $display("test calendar tick done");
    close_out();
  end
endmodule : bcdrtc_top_tb_top

bind bcdrtc_top bcdrtc_sva u_sva (.clk_sys, .rstn, .clk32kIn, .sleepState,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .periodic_tick_irq, .alarm_match_irq);
